// ---- afe_input_gain_offset_regs.sv ----
// Purpose: APB register bank steering the analog front end
// Assumes: sync, clamp-time and coast inputs synchronous to pclk
// Notes: every control output lags its register or input by one edge
// Behaviour
// R1 - bit 0 picks input set a or b
// R2 - ac coupling: clamp positive, tie negative internally
// R3 - dc coupling: both pads, no clamp
// R4 - rgb: half shift all, targets zero
// R5 - yuv: 600mV red/blue, green shift only
// R6 - sync mux by type and source bits
// R7 - coast clamp bit keeps restore during coast
// R8 - gain code sets 0.5 plus code/170
// R9 - loop on: offset is digital code shift
// R10 - loop off: offset drives upper DAC bits
// R11 - 0x80 means mid value or zero
// R12 - range bit picks half or quarter span
// R13 - config low bits complete ten-bit DAC
module afe_input_gain_offset_regs
  import afe_cfg_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // front-end state
  input wire logic clamp_time,
  input wire logic coasting,
  input wire logic auto_black_level_en,
  input wire logic hsync_in,
  input wire logic green_embedded_sync_in,
  // input routing and coupling
  output logic input_set_b_sel,
  output logic pos_to_clamp_dac,
  output logic neg_to_pad,
  output logic neg_tied_clamp_dac,
  output logic analog_clamp_en,
  // colour space
  output logic [2:0] clamp_level_600mv,
  output logic [2:0] half_scale_shift,
  output logic [7:0] red_black_target,
  output logic [7:0] green_black_target,
  output logic [7:0] blue_black_target,
  // sync and coast
  output logic sync_mux_out,
  output logic dc_restore_run,
  output logic auto_black_level_run,
  // gain and offset
  output logic [7:0] red_gain_code,
  output logic [7:0] green_gain_code,
  output logic [7:0] blue_gain_code,
  output logic offset_quarter_span,
  output logic signed [7:0] red_digital_offset,
  output logic signed [7:0] green_digital_offset,
  output logic signed [7:0] blue_digital_offset,
  output logic [9:0] red_offset_dac,
  output logic [9:0] green_offset_dac,
  output logic [9:0] blue_offset_dac
);

  // live register contents shared between storage and the decode below
  cfg_bank_if bank ();

  // ************************************************************
  // apb slave
  // ************************************************************
  apb_state_t state_r, state_nxt;
  logic pready_nxt, pslverr_nxt;
  logic [31:0] prdata_nxt;
  logic [7:0] status_r, status_nxt;
  logic [5:0] idx;
  logic aligned, hit, rd_status, bad_addr, wr_en;
  logic [7:0] rd_byte;

  assign idx = word_index(paddr);
  assign aligned = (paddr[1:0] == 2'b00);
  assign hit = in_bank(idx) && aligned;
  // status word is read only: writes to it are dropped without an error
  assign rd_status = (idx == IDX_FRONT_STATUS) && aligned;
  assign bad_addr = !hit && !rd_status;
  // write lands at the edge where the master sees pready high, so an
  // access dropped before its answer never touches storage
  assign wr_en = psel && penable && pwrite && pready && hit;

  cfg_store store (
    .pclk(pclk),
    .presetn(presetn),
    .we(wr_en),
    .waddr(slot_of(idx)),
    .wdata(pwdata[7:0]),
    .raddr(slot_of(idx)),
    .rdata_r(rd_byte),
    .bank(bank.store)
  );

  // two-step answer: the store's read port is registered, so the byte is
  // ready one edge after setup and pready with prdata one edge later
  always_comb begin
    state_nxt = state_r;
    pready_nxt = 1'b0;
    pslverr_nxt = 1'b0;
    prdata_nxt = 32'h0000_0000;
    case (state_r)
      APB_IDLE: begin
        if (psel && !penable) begin
          state_nxt = APB_ANSWER;
        end
      end
      APB_ANSWER: begin
        state_nxt = APB_IDLE;
        pready_nxt = 1'b1;
        pslverr_nxt = bad_addr;
        // refused and write transfers read back zero
        if (!pwrite && !bad_addr) begin
          prdata_nxt = {24'h00_0000, rd_status ? status_r : rd_byte};
        end
      end
      default: begin
        state_nxt = APB_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= APB_IDLE;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      state_r <= state_nxt;
      pready <= pready_nxt;
      pslverr <= pslverr_nxt;
      prdata <= prdata_nxt;
    end
  end

  // ************************************************************
  // front-end controls
  // ************************************************************
  logic [7:0] cfg, ofs_cfg;
  logic dc_cpl, yuv, restore_ok;
  logic set_b_nxt, pos_clamp_nxt, neg_pad_nxt, neg_tie_nxt;
  logic aclamp_nxt, sync_nxt, restore_nxt, black_run_nxt, quarter_nxt;
  logic [2:0] clamp_nxt, shift_nxt;
  logic [7:0] rt_nxt, gt_nxt, bt_nxt;
  logic [7:0] rg_nxt, gg_nxt, bg_nxt;

  assign cfg = bank.regs[SLOT_INPUT];
  assign ofs_cfg = bank.regs[SLOT_OFSCFG];
  assign dc_cpl = cfg[B_DC_COUPLED];
  assign yuv = cfg[B_YUV];

  always_comb begin
    set_b_nxt = cfg[B_CHAN_SEL];  // R1
    // ac: negative leg never reaches the pad
    pos_clamp_nxt = !dc_cpl && clamp_time;  // R2
    neg_tie_nxt = !dc_cpl;  // R2
    neg_pad_nxt = dc_cpl;  // R3
    // suspended during coast unless the coast clamp bit is set
    restore_ok = !coasting || cfg[B_COAST_CLAMP];  // R7
    aclamp_nxt = !dc_cpl && clamp_time && restore_ok;  // R2 R3
    restore_nxt = restore_ok && !dc_cpl;  // R3 R7
    black_run_nxt = restore_ok && auto_black_level_en;  // R7
    // channel order {blue, green, red}
    if (yuv) begin
      clamp_nxt = {CLAMP_600MV, CLAMP_300MV, CLAMP_600MV};  // R5
      shift_nxt = 3'b010;  // R5
      rt_nxt = TARGET_MID;  // R5
      gt_nxt = TARGET_ZERO;  // R5
      bt_nxt = TARGET_MID;  // R5
    end else begin
      clamp_nxt = {CLAMP_300MV, CLAMP_300MV, CLAMP_300MV};  // R4
      shift_nxt = 3'b111;  // R4
      rt_nxt = TARGET_ZERO;  // R4
      gt_nxt = TARGET_ZERO;  // R4
      bt_nxt = TARGET_ZERO;  // R4
    end
    // green-embedded sync only when composite type and source bit 0
    if (cfg[B_SYNC_COMPOSITE] && !cfg[B_SYNC_SRC_PIN]) begin
      sync_nxt = green_embedded_sync_in;  // R6
    end else begin
      sync_nxt = hsync_in;  // R6
    end
    // analog stage realises 0.5 + code/170 from the raw code
    rg_nxt = bank.regs[SLOT_RGAIN];  // R8
    gg_nxt = bank.regs[SLOT_GGAIN];  // R8
    bg_nxt = bank.regs[SLOT_BGAIN];  // R8
    quarter_nxt = ofs_cfg[B_OFS_RANGE];  // R12
  end

  // reset state mirrors the register reset values: set a, ac, rgb
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_set_b_sel <= 1'b0;
      pos_to_clamp_dac <= 1'b0;
      neg_to_pad <= 1'b0;
      neg_tied_clamp_dac <= 1'b1;
      analog_clamp_en <= 1'b0;
      clamp_level_600mv <= 3'b000;
      half_scale_shift <= 3'b111;
      red_black_target <= TARGET_ZERO;
      green_black_target <= TARGET_ZERO;
      blue_black_target <= TARGET_ZERO;
      sync_mux_out <= 1'b0;
      dc_restore_run <= 1'b0;
      auto_black_level_run <= 1'b0;
      red_gain_code <= REG_RESET[SLOT_RGAIN];
      green_gain_code <= REG_RESET[SLOT_GGAIN];
      blue_gain_code <= REG_RESET[SLOT_BGAIN];
      offset_quarter_span <= 1'b0;
    end else begin
      input_set_b_sel <= set_b_nxt;
      pos_to_clamp_dac <= pos_clamp_nxt;
      neg_to_pad <= neg_pad_nxt;
      neg_tied_clamp_dac <= neg_tie_nxt;
      analog_clamp_en <= aclamp_nxt;
      clamp_level_600mv <= clamp_nxt;
      half_scale_shift <= shift_nxt;
      red_black_target <= rt_nxt;
      green_black_target <= gt_nxt;
      blue_black_target <= bt_nxt;
      sync_mux_out <= sync_nxt;
      dc_restore_run <= restore_nxt;
      auto_black_level_run <= black_run_nxt;
      red_gain_code <= rg_nxt;
      green_gain_code <= gg_nxt;
      blue_gain_code <= bg_nxt;
      offset_quarter_span <= quarter_nxt;
    end
  end

  // ************************************************************
  // status word
  // ************************************************************
  // shows next-edge control values, so software sees what the pads get
  localparam int S_LOOP_EN = 0;
  localparam int S_COASTING = 1;
  localparam int S_SYNC = 2;
  localparam int S_ACLAMP = 3;
  localparam int S_RESTORE = 4;
  localparam int S_BLACK_RUN = 5;

  always_comb begin
    status_nxt = 8'h00;
    status_nxt[S_LOOP_EN] = auto_black_level_en;
    status_nxt[S_COASTING] = coasting;
    status_nxt[S_SYNC] = sync_nxt;
    status_nxt[S_ACLAMP] = aclamp_nxt;
    status_nxt[S_RESTORE] = restore_nxt;
    status_nxt[S_BLACK_RUN] = black_run_nxt;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r <= 8'h00;
    end else begin
      status_r <= status_nxt;
    end
  end

  // ************************************************************
  // per-channel offsets
  // ************************************************************
  // the loop enable is a plain input, its register lies outside this
  // bank; by it each path zeroes its digital offset or holds its DAC code
  offset_path red_ofs (
    .pclk(pclk),
    .presetn(presetn),
    .auto_black_level_en(auto_black_level_en),
    .offset_code(bank.regs[SLOT_ROFS]),
    .offset_lsbs(ofs_cfg[B_RED_LSB +: 2]),  // R13
    .digital_offset_r(red_digital_offset),
    .dac_code_r(red_offset_dac)
  );

  offset_path green_ofs (
    .pclk(pclk),
    .presetn(presetn),
    .auto_black_level_en(auto_black_level_en),
    .offset_code(bank.regs[SLOT_GOFS]),
    .offset_lsbs(ofs_cfg[B_GREEN_LSB +: 2]),  // R13
    .digital_offset_r(green_digital_offset),
    .dac_code_r(green_offset_dac)
  );

  offset_path blue_ofs (
    .pclk(pclk),
    .presetn(presetn),
    .auto_black_level_en(auto_black_level_en),
    .offset_code(bank.regs[SLOT_BOFS]),
    .offset_lsbs(ofs_cfg[B_BLUE_LSB +: 2]),  // R13
    .digital_offset_r(blue_digital_offset),
    .dac_code_r(blue_offset_dac)
  );

endmodule

// ---- afe_cfg_pkg.sv ----
// Purpose: shared constants and helpers for the front-end config bank
// Assumes: APB slave, 32-bit data, one 8-bit register per aligned word
// Notes: register indices are word indices; byte address is index * 4
package afe_cfg_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam int REG_NUM = 8;
  localparam int REG_AW = 3;
  localparam logic [5:0] IDX_INPUT_SETUP = 6'h05;
  localparam logic [5:0] IDX_RED_GAIN = 6'h06;
  localparam logic [5:0] IDX_GREEN_GAIN = 6'h07;
  localparam logic [5:0] IDX_BLUE_GAIN = 6'h08;
  localparam logic [5:0] IDX_RED_OFFSET = 6'h09;
  localparam logic [5:0] IDX_GREEN_OFFSET = 6'h0A;
  localparam logic [5:0] IDX_BLUE_OFFSET = 6'h0B;
  localparam logic [5:0] IDX_OFFSET_CFG = 6'h0C;
  localparam logic [5:0] IDX_FRONT_STATUS = 6'h20;
  localparam logic [5:0] IDX_FIRST = IDX_INPUT_SETUP;
  localparam logic [5:0] IDX_LAST = IDX_OFFSET_CFG;

  // storage slots, index minus the first index
  localparam logic [REG_AW-1:0] SLOT_INPUT = 3'h0;
  localparam logic [REG_AW-1:0] SLOT_RGAIN = 3'h1;
  localparam logic [REG_AW-1:0] SLOT_GGAIN = 3'h2;
  localparam logic [REG_AW-1:0] SLOT_BGAIN = 3'h3;
  localparam logic [REG_AW-1:0] SLOT_ROFS = 3'h4;
  localparam logic [REG_AW-1:0] SLOT_GOFS = 3'h5;
  localparam logic [REG_AW-1:0] SLOT_BOFS = 3'h6;
  localparam logic [REG_AW-1:0] SLOT_OFSCFG = 3'h7;

  localparam logic [7:0] REG_RESET [REG_NUM] = '{
    8'h00, 8'h55, 8'h55, 8'h55, 8'h80, 8'h80, 8'h80, 8'h00};
  // reserved bits stay zero: input_setup 7:6, offset config bit 1
  localparam logic [7:0] REG_WMASK [REG_NUM] = '{
    8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFD};

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int B_CHAN_SEL = 0;
  localparam int B_DC_COUPLED = 1;
  localparam int B_YUV = 2;
  localparam int B_SYNC_COMPOSITE = 3;
  localparam int B_SYNC_SRC_PIN = 4;
  localparam int B_COAST_CLAMP = 5;
  localparam int B_OFS_RANGE = 0;
  localparam int B_RED_LSB = 2;
  localparam int B_GREEN_LSB = 4;
  localparam int B_BLUE_LSB = 6;

  // ************************************************************
  // analog codes
  // ************************************************************
  localparam logic CLAMP_300MV = 1'b0;
  localparam logic CLAMP_600MV = 1'b1;
  localparam logic [7:0] TARGET_ZERO = 8'h00;
  localparam logic [7:0] TARGET_MID = 8'h80;
  localparam logic [7:0] OFFSET_MID = 8'h80;

  typedef enum logic [1:0] {
    APB_IDLE = 2'b00,
    APB_ANSWER = 2'b01
  } apb_state_t;

  function automatic logic [5:0] word_index(input logic [7:0] addr);
    return addr[7:2];
  endfunction

  function automatic logic in_bank(input logic [5:0] idx);
    return (idx >= IDX_FIRST) && (idx <= IDX_LAST);
  endfunction

  function automatic logic [REG_AW-1:0] slot_of(input logic [5:0] idx);
    logic [5:0] d;
    d = idx - IDX_FIRST;
    return d[REG_AW-1:0];
  endfunction

endpackage

// ---- cfg_bank_if.sv ----
// Purpose: carries the live register contents from storage to users
// Assumes: storage drives, decode logic only reads
// Notes: contents change one edge after an accepted write
interface cfg_bank_if;
  import afe_cfg_pkg::*;
  logic [7:0] regs [REG_NUM];
  modport store (output regs);
  modport reader (input regs);
endinterface

// ---- cfg_store.sv ----
// Purpose: eight-byte register storage with registered read port
// Assumes: one write and one read per cycle at most
// Notes: reserved bits are masked on write so they always read zero
module cfg_store
  import afe_cfg_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // access port
  input wire logic we,
  input wire logic [REG_AW-1:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [REG_AW-1:0] raddr,
  output logic [7:0] rdata_r,
  // live contents
  cfg_bank_if.store bank
);

  logic [7:0] mem_r [REG_NUM];
  logic [7:0] mem_nxt [REG_NUM];
  logic [7:0] rdata_nxt;

  always_comb begin
    for (int i = 0; i < REG_NUM; i++) begin
      mem_nxt[i] = mem_r[i];
    end
    if (we) begin
      mem_nxt[waddr] = wdata & REG_WMASK[waddr];
    end
    rdata_nxt = mem_r[raddr];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < REG_NUM; i++) begin
        mem_r[i] <= REG_RESET[i];
      end
      rdata_r <= 8'h00;
    end else begin
      for (int i = 0; i < REG_NUM; i++) begin
        mem_r[i] <= mem_nxt[i];
      end
      rdata_r <= rdata_nxt;
    end
  end

  always_comb begin
    for (int i = 0; i < REG_NUM; i++) begin
      bank.regs[i] = mem_r[i];
    end
  end

endmodule

// ---- offset_path.sv ----
// Purpose: one channel's offset meaning, digital or analog
// Assumes: black-level loop enable is a level from the loop itself
// Notes: digital offset forced to zero with loop off; DAC code held with loop on
module offset_path
  import afe_cfg_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // settings
  input wire logic auto_black_level_en,
  input wire logic [7:0] offset_code,
  input wire logic [1:0] offset_lsbs,
  // results
  output logic signed [7:0] digital_offset_r,
  output logic [9:0] dac_code_r
);

  logic signed [7:0] digital_offset_nxt;
  logic [9:0] dac_code_nxt;

  always_comb begin
    // 0x00 -> -0x80, 0x80 -> 0, 0xFF -> +0x7F: one code per step
    digital_offset_nxt = auto_black_level_en ?
      $signed(offset_code - OFFSET_MID) : 8'sh00;  // R9 R11
    // register supplies the upper eight DAC bits
    dac_code_nxt = auto_black_level_en ? dac_code_r :
      {offset_code, offset_lsbs};  // R10 R11 R13
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      digital_offset_r <= 8'sh00;
      dac_code_r <= {OFFSET_MID, 2'b00};
    end else begin
      digital_offset_r <= digital_offset_nxt;
      dac_code_r <= dac_code_nxt;
    end
  end

endmodule

// ---- afe_input_gain_offset_regs_assertions.sv ----
// Purpose: port-level checks on the front-end config bank
// Assumes: one clock domain, presetn async and active low
// Notes: controls lag their inputs by one edge, apb writes by two
module afe_cfg_checker (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // front-end inputs
  input wire logic clamp_time,
  input wire logic coasting,
  input wire logic auto_black_level_en,
  input wire logic hsync_in,
  input wire logic green_embedded_sync_in,
  // controls
  input wire logic input_set_b_sel,
  input wire logic pos_to_clamp_dac,
  input wire logic neg_to_pad,
  input wire logic neg_tied_clamp_dac,
  input wire logic analog_clamp_en,
  input wire logic [2:0] clamp_level_600mv,
  input wire logic [2:0] half_scale_shift,
  input wire logic [7:0] red_black_target,
  input wire logic [7:0] green_black_target,
  input wire logic sync_mux_out,
  input wire logic auto_black_level_run,
  input wire logic [7:0] red_gain_code,
  input wire logic signed [7:0] red_digital_offset,
  input wire logic [9:0] red_offset_dac
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr_ok;
  assign wr_ok = psel && penable && pready && pwrite && !pslverr;

  // ****************
  // assertions
  // ****************
  a_set_select: assert property (
    wr_ok && paddr == 8'h14 |-> ##2 input_set_b_sel == $past(pwdata[0], 2))
    else $error("input set select wrong");
  a_gain_write: assert property (
    wr_ok && paddr == 8'h18 |-> ##2 red_gain_code == $past(pwdata[7:0], 2))
    else $error("gain code wrong");
  a_ac_clamp: assert property (
    pos_to_clamp_dac |-> $past(clamp_time) && neg_tied_clamp_dac)
    else $error("positive input clamped outside clamp time");
  a_dc_coupled: assert property (
    (neg_to_pad ^ neg_tied_clamp_dac) &&
    !(neg_to_pad && (pos_to_clamp_dac || analog_clamp_en)))
    else $error("coupling controls inconsistent");
  a_colour_set: assert property (
    clamp_level_600mv == 3'b101 ? (half_scale_shift == 3'b010 &&
      red_black_target == 8'h80 && green_black_target == 8'h00) :
    (clamp_level_600mv == 3'b000 && half_scale_shift == 3'b111 &&
      red_black_target == 8'h00 && green_black_target == 8'h00))
    else $error("colour space controls inconsistent");
  a_sync_source: assert property (
    $past(presetn) |-> sync_mux_out == $past(hsync_in) ||
    sync_mux_out == $past(green_embedded_sync_in))
    else $error("sync mux passes neither source");
  a_coast_run: assert property (
    $past(presetn) && !$past(coasting) |->
    auto_black_level_run == $past(auto_black_level_en))
    else $error("black-level run wrong outside coast");
  a_digital_zero: assert property (
    $past(presetn) && !$past(auto_black_level_en) |->
    red_digital_offset == 8'h00)
    else $error("digital offset live with loop off");
  a_dac_hold: assert property (
    $past(presetn) && $past(auto_black_level_en) |-> $stable(red_offset_dac))
    else $error("offset dac moved with loop on");
  a_ready_pulse: assert property (
    psel && !penable |=> !pready ##1 pready ##1 !pready)
    else $error("pready not a single answer cycle");
endmodule

bind afe_input_gain_offset_regs afe_cfg_checker afe_cfg_checker_inst (.*);

// ---- tb_afe_input_gain_offset_regs.sv ----
// Purpose: directed bench for the front-end config bank
// Assumes: outputs settle within three edges of a write
// Notes: loop enable, coast and sync inputs are driven directly
module tb_afe_input_gain_offset_regs;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // signals
  // ****************
  logic pclk = 1'b0, presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic clamp_time = 1'b1, coasting = 1'b0, auto_black_level_en = 1'b0;
  logic hsync_in = 1'b1, green_embedded_sync_in = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, input_set_b_sel, pos_to_clamp_dac, neg_to_pad;
  logic neg_tied_clamp_dac, analog_clamp_en, sync_mux_out;
  logic dc_restore_run, auto_black_level_run, offset_quarter_span;
  logic [2:0] clamp_level_600mv, half_scale_shift;
  logic [7:0] red_black_target, green_black_target, blue_black_target;
  logic [7:0] red_gain_code, green_gain_code, blue_gain_code;
  logic signed [7:0] red_digital_offset, green_digital_offset;
  logic signed [7:0] blue_digital_offset;
  logic [9:0] red_offset_dac, green_offset_dac, blue_offset_dac;
  int err_count = 0;
  int comparisons = 0;
  localparam logic [7:0] RST_VAL [8] = '{8'h00, 8'h55, 8'h55, 8'h55,
    8'h80, 8'h80, 8'h80, 8'h00};
  // reserved bits never store
  localparam logic [7:0] KEEP [8] = '{8'h3F, 8'hFF, 8'hFF, 8'hFF,
    8'hFF, 8'hFF, 8'hFF, 8'hFD};

  afe_input_gain_offset_regs afe_input_gain_offset_regs_inst (.*);

  initial begin
    forever #4 pclk = ~pclk;
  end

  // ****************
  // tasks
  // ****************
  task automatic final_report();
    $display("comparisons %0d errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      err_count++;
      $display("[ERR] %0t no pready", $time);
      final_report();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, {24'h0, d}, r, e);
    repeat (3) @(posedge pclk);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] d,
      input logic ee);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    check(r, {24'h0, d});
    check(e, ee);
  endtask

  task automatic t_reset();
    for (int i = 0; i < 8; i++) rchk(8'((5 + i) * 4), RST_VAL[i], 1'b0);
    check(red_gain_code, 8'h55);
    check(red_offset_dac, 10'h200);
  endtask

  task automatic t_masks();
    for (int i = 0; i < 8; i++) wr(8'((5 + i) * 4), 8'hFF);
    for (int i = 0; i < 8; i++) rchk(8'((5 + i) * 4), KEEP[i], 1'b0);
    check(input_set_b_sel, 1'b1);
    check({neg_to_pad, pos_to_clamp_dac, analog_clamp_en}, 3'b100);
    check({green_gain_code, blue_gain_code}, 16'hFFFF);
    check(offset_quarter_span, 1'b1);
    check(red_offset_dac, 10'h3FF);
  endtask

  task automatic t_colour();
    for (int m = 0; m < 2; m++) begin
      wr(8'h14, m[0] ? 8'h04 : 8'h00);
      check(clamp_level_600mv, m[0] ? 3'b101 : 3'b000);
      check(half_scale_shift, m[0] ? 3'b010 : 3'b111);
      check({red_black_target, green_black_target, blue_black_target},
        m[0] ? 24'h800080 : 24'h0);
      check({neg_to_pad, neg_tied_clamp_dac, pos_to_clamp_dac}, 3'b011);
      check(input_set_b_sel, 1'b0);
    end
    clamp_time <= 1'b0;
    repeat (2) @(posedge pclk);
    check({pos_to_clamp_dac, analog_clamp_en}, 2'b00);
    clamp_time <= 1'b1;
    repeat (2) @(posedge pclk);
    check({pos_to_clamp_dac, analog_clamp_en}, 2'b11);
  endtask

  task automatic t_sync();
    for (int s = 0; s < 4; s++) begin
      wr(8'h14, {3'b000, s[1], s[0], 3'b000});
      check(sync_mux_out, !(s[0] && !s[1]));
    end
  endtask

  task automatic t_offset_dac();
    wr(8'h30, 8'hE4);
    wr(8'h24, 8'h12);
    check(offset_quarter_span, 1'b0);
    check(red_offset_dac, 10'h049);
    check({green_offset_dac, blue_offset_dac}, 20'hFFBFF);
  endtask

  task automatic t_coast();
    coasting <= 1'b1;
    auto_black_level_en <= 1'b1;
    for (int c = 0; c < 2; c++) begin
      wr(8'h14, c[0] ? 8'h20 : 8'h00);
      check({auto_black_level_run, dc_restore_run, analog_clamp_en},
        c[0] ? 3'b111 : 3'b000);
    end
    coasting <= 1'b0;
  endtask

  task automatic t_digital();
    logic [7:0] v [3] = '{8'h00, 8'h80, 8'hFF};
    logic [7:0] x [3] = '{8'h80, 8'h00, 8'h7F};
    for (int k = 0; k < 3; k++) begin
      wr(8'h24, v[k]);
      check($unsigned(red_digital_offset), x[k]);
      check(red_offset_dac, 10'h049);
    end
    check($unsigned(green_digital_offset), 8'h7F);
  endtask

  task automatic t_refused();
    logic [31:0] r;
    logic e;
    // status word: loop on, no coast, hsync high, clamp, restore, run
    rchk(8'h80, 8'h3D, 1'b0);
    apb(1'b1, 8'h80, 32'h0, r, e);
    check(e, 1'b0);
    rchk(8'h80, 8'h3D, 1'b0);
    rchk(8'h40, 8'h00, 1'b1);
    apb(1'b1, 8'h19, 32'h0, r, e);
    check(e, 1'b1);
    rchk(8'h15, 8'h00, 1'b1);
    rchk(8'h18, 8'hFF, 1'b0);
    wr(8'h18, 8'h00);
    check(red_gain_code, 8'h00);
  endtask

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_masks();
    t_colour();
    t_sync();
    t_offset_dac();
    t_coast();
    t_digital();
    t_refused();
    final_report();
  end
endmodule
